// *** shared/dram_mode_pkg.sv ***
// Shared constants and types for the interleaved DRAM mode and timing block
package dram_mode_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_REG_ADDR = 32'h0100_0000;
  localparam logic [31:0] DRAM_LOW_ADDR = 32'h0000_0000;
  localparam logic [31:0] DRAM_HIGH_ADDR = 32'h00ff_fffc;

  // ----------------------------------------------------------------
  // Mode word field layout
  // ----------------------------------------------------------------
  localparam int PAGE_SIZE_LSB = 0;
  localparam int INTERLEAVE_BIT = 2;
  localparam int ROW_COL_DELAY_BIT = 3;
  localparam int CAS_WIDTH_BIT = 4;
  localparam logic [1:0] PAGE_SIZE_RESET = 2'h2;
  localparam logic INTERLEAVE_RESET = 1'b1;
  localparam logic ROW_COL_DELAY_RESET = 1'b0;
  localparam logic CAS_WIDTH_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Timing counts in half cycles of the 100 MHz clock
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int RAS_CAS_FAST_HALF = 2;
  localparam int RAS_CAS_SLOW_HALF = 4;
  localparam int CAS_PULSE_SHORT_HALF = 3;
  localparam int CAS_PULSE_LONG_HALF = 5;
  localparam int RAS_AFTER_CAS_HALF = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cas_width;
    logic row_to_column_delay_bit;
    logic interleave;
    logic [1:0] page_size_field;
  } mode_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic start;
  } cpu_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW = 3'b001,
    ST_COL = 3'b010,
    ST_CAS = 3'b011,
    ST_END = 3'b100
  } phase_t;

endpackage

// *** logic/sync3.sv ***
// Three-stage synchroniser for one external level
`timescale 1ns/1ns
`default_nettype none
module sync3 (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reset_value,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else if (ce) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a change only once the second and third stages agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dout <= 1'b1;
    end else if (ce && (s2_reg == s3_reg)) begin
      dout <= s3_reg;
    end
  end

  logic unused_rv;
  assign unused_rv = reset_value;
endmodule
`default_nettype wire

// *** logic/dram_mode_setup.sv ***
// Mode word capture and row/column strobe timing for two interleaved bank-pairs
`timescale 1ns/1ns
`default_nettype none
// How it works
// - mode word sits at its own I/O address
// - two bank-pairs, even and odd 32-bit arrays
// - row strobe 0 even, 1 odd, repeating
// - interleave bit set runs interleaved configuration
// - delay bit sets row-to-column spacing in cycles
// - delay 0 switches address one cycle after row, with the column strobe
// - delay 0 column strobe one cycle after row
// - column strobe held 2 cycles on reads, 3 with cas_width set
// - column strobes drop when read data sampled
// - delay 1 column address at 1, strobe next rise
// - row strobes drop one cycle after column strobes
module dram_mode_setup #(
  parameter int BANK_PAIRS = 2,
  parameter int ADDR_BITS = 10
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Processor side
  input wire dram_mode_pkg::cpu_req_t cpu_req,
  input wire logic dram_cs_n,
  input wire logic register_select_n,
  output logic data_sample,
  output logic busy,
  // Mode word status
  output dram_mode_pkg::mode_t mode_out,
  // DRAM side
  output logic [2*BANK_PAIRS-1:0] ras_n,
  output logic [2*BANK_PAIRS-1:0] cas_n,
  output logic [ADDR_BITS-1:0] dram_mux_address
);
  import dram_mode_pkg::*;

  // ----------------------------------------------------------------
  // Select inputs from the external decoder
  // ----------------------------------------------------------------
  logic cs_n_s;
  logic rsel_n_s;

  sync3 u_cs (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reset_value(1'b1),
    .din(dram_cs_n), .dout(cs_n_s)
  );
  sync3 u_rsel (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reset_value(1'b1),
    .din(register_select_n), .dout(rsel_n_s)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  localparam int BANK_BITS = $clog2(2 * BANK_PAIRS);
  phase_t phase_reg;
  phase_t phase_next;
  mode_t mode_reg;
  logic [3:0] half_cnt_reg;
  logic [BANK_BITS-1:0] bank_reg;
  logic write_reg;
  logic [ADDR_BITS-1:0] col_reg;
  wire idle_w = (phase_reg == ST_IDLE);
  // Both selects on a write reach the mode word, never the array
  wire mode_wr_w = idle_w && cpu_req.start && cpu_req.write && !cs_n_s && !rsel_n_s;
  // Chip select alone starts an array access anywhere in the window
  wire dram_go_w = idle_w && cpu_req.start && !cs_n_s && rsel_n_s;
  // Interleaved: address bit 2 picks odd array; bit 3 picks the pair
  wire [BANK_BITS-1:0] bank_w = mode_reg.interleave ?
    cpu_req.addr[BANK_BITS+1:2] : {cpu_req.addr[BANK_BITS+1:3], 1'b0};
  wire [ADDR_BITS-1:0] row_w = cpu_req.addr[2*ADDR_BITS+3:ADDR_BITS+4];
  wire [ADDR_BITS-1:0] colw_w = cpu_req.addr[ADDR_BITS+3:4];
  wire [3:0] rc_half_w = mode_reg.row_to_column_delay_bit ?
    4'(RAS_CAS_SLOW_HALF) : 4'(RAS_CAS_FAST_HALF);
  wire [3:0] cas_half_w = mode_reg.cas_width ?
    4'(CAS_PULSE_LONG_HALF) : 4'(CAS_PULSE_SHORT_HALF);
  // Last step of a phase: even counts end at two, odd ones at one
  wire cnt_done_w = (half_cnt_reg <= 4'h2);

  // ----------------------------------------------------------------
  // Access sequencer, stepping on the rising edge only
  // ----------------------------------------------------------------
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      ST_IDLE: begin
        if (dram_go_w) begin
          phase_next = ST_ROW;
        end
      end
      ST_ROW: begin
        if (cnt_done_w) begin
          phase_next = ST_CAS;
        end
      end
      ST_CAS: begin
        if (cnt_done_w) begin
          phase_next = ST_END;
        end
      end
      ST_END: begin
        phase_next = ST_IDLE;
      end
      default: begin
        phase_next = ST_IDLE;
      end
    endcase
  end

  // Counter of half cycles; one tick per clock models two edges by pairs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= ST_IDLE;
      half_cnt_reg <= 4'h0;
      bank_reg <= '0;
      write_reg <= 1'b0;
      col_reg <= '0;
    end else if (ce) begin
      phase_reg <= phase_next;
      if (dram_go_w) begin
        half_cnt_reg <= rc_half_w;
        bank_reg <= bank_w;
        write_reg <= cpu_req.write;
        col_reg <= colw_w;
      end else if (phase_reg == ST_ROW && cnt_done_w) begin
        half_cnt_reg <= cas_half_w;
      end else if (half_cnt_reg > 4'h1) begin
        half_cnt_reg <= half_cnt_reg - 4'h2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode word
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= '{CAS_WIDTH_RESET, ROW_COL_DELAY_RESET, INTERLEAVE_RESET, PAGE_SIZE_RESET};
    end else if (ce && mode_wr_w) begin
      mode_reg.page_size_field <= cpu_req.wdata[PAGE_SIZE_LSB+1:PAGE_SIZE_LSB];
      mode_reg.interleave <= cpu_req.wdata[INTERLEAVE_BIT];
      mode_reg.row_to_column_delay_bit <= cpu_req.wdata[ROW_COL_DELAY_BIT];
      mode_reg.cas_width <= cpu_req.wdata[CAS_WIDTH_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Strobes and multiplexed address
  // ----------------------------------------------------------------
  wire ras_on_w = (phase_next == ST_ROW) || (phase_next == ST_CAS);
  wire cas_on_w = (phase_next == ST_CAS);
  // Row strobe stays low through END, one step past the column strobe
  wire ras_hold_w = ras_on_w || (phase_next == ST_END);
  wire [BANK_BITS-1:0] ras_bank_w = dram_go_w ? bank_w : bank_reg;
  // Column address one cycle after the row strobe, at the latest with the column strobe
  wire col_addr_w = (phase_reg == ST_ROW);
  wire [2*BANK_PAIRS-1:0] ras_sel_w;
  wire [2*BANK_PAIRS-1:0] cas_sel_w;

  genvar g;
  generate
    for (g = 0; g < 2 * BANK_PAIRS; g++) begin : g_bank
      assign ras_sel_w[g] = ras_hold_w && (ras_bank_w == BANK_BITS'(g));
      assign cas_sel_w[g] = cas_on_w && ((bank_reg >> 1) == (BANK_BITS'(g) >> 1));
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ras_n <= '1;
      cas_n <= '1;
      dram_mux_address <= '0;
      data_sample <= 1'b0;
      busy <= 1'b0;
      mode_out <= '{CAS_WIDTH_RESET, ROW_COL_DELAY_RESET, INTERLEAVE_RESET, PAGE_SIZE_RESET};
    end else if (ce) begin
      if (dram_go_w) begin
        dram_mux_address <= row_w;
      end else if (col_addr_w) begin
        dram_mux_address <= col_reg;
      end
      // Read data is taken on the edge the column strobe lets go
      data_sample <= (phase_reg == ST_CAS) && cnt_done_w && !write_reg;
      ras_n <= ~ras_sel_w;
      cas_n <= ~cas_sel_w;
      busy <= (phase_next != ST_IDLE);
      mode_out <= mode_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire any_ras_w = ~&ras_n;
  wire any_cas_w = ~&cas_n;

  mode_capture_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && mode_wr_w) |=> (mode_reg.interleave == $past(cpu_req.wdata[INTERLEAVE_BIT])))
    else $error("mode word not captured");
  mode_no_access_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && mode_wr_w) |=> !any_ras_w)
    else $error("mode write started array access");
  cas_after_ras_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(any_cas_w) |-> $past(any_ras_w, 1))
    else $error("column strobe without row strobe lead");
  ras_after_cas_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($fell(any_cas_w) && ce) |-> any_ras_w ##1 !any_ras_w)
    else $error("row strobe not released after column strobe");
  cas_width_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(any_cas_w) |=> any_cas_w)
    else $error("column strobe too short");
  sample_edge_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(data_sample) |-> $fell(any_cas_w))
    else $error("column strobe not released at sample");
  one_ras_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $onehot0(~ras_n))
    else $error("more than one row strobe low");
  go_ras_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && dram_go_w) |=> any_ras_w && any_cas_w == 1'b0)
    else $error("row strobe not first");
endmodule
`default_nettype wire

// *** dv/addr_decoder_model.sv ***
// Address decoder model producing the controller's select lines
`timescale 1ns/1ns
`default_nettype none
module addr_decoder_model (
  // Latched processor request
  input wire dram_mode_pkg::cpu_req_t cpu_req,
  // Selects to the controller
  output logic dram_cs_n,
  output logic register_select_n
);
  import dram_mode_pkg::*;
  logic in_dram;
  logic is_mode;
  assign in_dram = (cpu_req.addr >= DRAM_LOW_ADDR) && (cpu_req.addr <= DRAM_HIGH_ADDR);
  assign is_mode = (cpu_req.addr == MODE_REG_ADDR) && cpu_req.write;
  assign dram_cs_n = ~(in_dram | is_mode);
  assign register_select_n = ~is_mode;
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the DRAM mode and strobe timing block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dram_mode_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  cpu_req_t cpu_req = '0;
  logic dram_cs_n, register_select_n, data_sample, busy;
  mode_t mode_out, cur;
  logic [3:0] ras_n, cas_n;
  logic [9:0] dram_mux_address;
  logic [31:0] r;
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h2f8b;
  int k, j;

  always #5 ref_clk = ~ref_clk;

  addr_decoder_model dec_u (.cpu_req(cpu_req), .dram_cs_n(dram_cs_n),
    .register_select_n(register_select_n));
  dram_mode_setup dut_u (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .cpu_req(cpu_req),
    .dram_cs_n(dram_cs_n), .register_select_n(register_select_n), .data_sample(data_sample),
    .busy(busy), .mode_out(mode_out), .ras_n(ras_n), .cas_n(cas_n),
    .dram_mux_address(dram_mux_address));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Interleaved: address bit 2 picks the odd array, bit 3 the bank-pair
  function automatic logic [3:0] exp_ras(input logic [31:0] a);
    return ~(4'h1 << {a[3], a[2]});
  endfunction

  function automatic logic [3:0] exp_cas(input logic [31:0] a);
    return ~(4'h3 << {a[3], 1'b0});
  endfunction

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic set_req(input logic [31:0] a, input logic [31:0] d, input logic w,
                         input logic s);
    @(posedge ref_clk);
    cpu_req <= '{addr: a, wdata: d, write: w, start: s};
  endtask

  task automatic mode_write(input mode_t m);
    // Selects need a few edges through the synchronisers before start rises
    set_req(MODE_REG_ADDR, {27'h0, m}, 1'b1, 1'b0);
    repeat (6) tick();
    set_req(MODE_REG_ADDR, {27'h0, m}, 1'b1, 1'b1);
    repeat (3) tick();
    chk("mode_out", {27'h0, m}, {27'h0, mode_out});
    chk("busy on mode write", 32'h0, {31'h0, busy});
    // Park outside both windows so stale synced selects cannot retrigger
    set_req(32'h0200_0000, 32'h0, 1'b0, 1'b0);
    repeat (8) tick();
    cur = m;
  endtask

  task automatic access(input logic [31:0] a, input logic w);
    int t, tr, tc, tu, ts, te;
    logic seen;
    logic [3:0] er, ec;
    logic [9:0] row, col;
    er = exp_ras(a);
    ec = exp_cas(a);
    tr = -1; tc = -1; tu = -1; ts = -1; te = -1; seen = 1'b0; row = '0; col = '0;
    set_req(a, $random(seed), w, 1'b0);
    repeat (6) tick();
    set_req(a, cpu_req.wdata, w, 1'b1);
    for (t = 0; t < 40 && !(te >= 0 && busy === 1'b0); t++) begin
      @(posedge ref_clk);
      if (seen) cpu_req.start <= 1'b0;
      #1;
      if (busy === 1'b1) seen = 1'b1;
      if (tr < 0 && ras_n !== 4'hf) begin
        tr = t;
        row = dram_mux_address;
        chk("ras_n", {28'h0, er}, {28'h0, ras_n});
      end
      if (tc < 0 && cas_n !== 4'hf) begin
        tc = t;
        col = dram_mux_address;
        chk("cas_n", {28'h0, ec}, {28'h0, cas_n});
      end
      if (tc >= 0 && tu < 0 && cas_n === 4'hf) tu = t;
      if (data_sample === 1'b1) ts = t;
      if (tr >= 0 && te < 0 && ras_n === 4'hf) te = t;
    end
    chk("row address", {22'h0, a[23:14]}, {22'h0, row});
    chk("column address", {22'h0, a[13:4]}, {22'h0, col});
    if (cur.row_to_column_delay_bit) chk("ras to cas", 32'd2, tc - tr);
    else chk("ras to cas", 32'd1, tc - tr);
    chk("cas width", cur.cas_width ? 32'd3 : 32'd2, tu - tc);
    chk("data_sample", w ? -1 : tu, ts);
    chk("cas to ras release", 32'd1, te - tu);
    chk("mode kept", {27'h0, cur}, {27'h0, mode_out});
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) tick();
    cur = '{CAS_WIDTH_RESET, ROW_COL_DELAY_RESET, INTERLEAVE_RESET, PAGE_SIZE_RESET};
    chk("mode reset", {27'h0, cur}, {27'h0, mode_out});
    access(DRAM_LOW_ADDR, 1'b0);
    access(DRAM_HIGH_ADDR, 1'b1);
    for (k = 0; k < 4; k++) begin
      r = $random(seed);
      // Page size random, delay 1 exercised as for a heavy row load
      mode_write('{k[0], k[1], 1'b1, r[1:0]});
      for (j = 0; j < 3; j++) begin
        r = $random(seed);
        access({8'h0, r[23:2], 2'b00}, r[31]);
      end
    end
    final_report();
  end

  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
